// ---- rtl/refu_pkg.sv ----
// constants for the radio event flag unit
package refu_pkg;
  // register offsets
  localparam logic [5:0] ADDR_CTRL_ONE  = 6'h04;
  localparam logic [5:0] ADDR_ENABLE    = 6'h0e;
  localparam logic [5:0] ADDR_FLAGS     = 6'h0f;
  // control-one field positions
  localparam int BIT_STAMP_EN   = 6;
  localparam int BIT_BUF_EMPTY  = 4;
  localparam int BIT_SHOW_MASK  = 1;
  localparam int BIT_INVERT     = 0;
  // reset values
  localparam logic [7:0] CTRL_ONE_RESET = 8'h22;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_RESET    = 8'h00;
  // event bit positions
  localparam int EV_SYNTH_LOCK   = 0;
  localparam int EV_SYNTH_UNLOCK = 1;
  localparam int EV_FRAME_START  = 2;
endpackage : refu_pkg

// ---- rtl/refu_event_flags.sv ----
// event enable, flag and request pin logic of the radio
`timescale 1ns/1ps
// Contract
// R1: with show-masked set, every event is latched into flags regardless of enable.
// R2: enable zero and show-masked zero: pin inactive, no flags recorded.
// R3: enable zero and show-masked one: pin inactive, all events flagged.
// R4: some enables, show-masked zero: enabled events on pin and in flags.
// R5: show-masked zero never sets a flag whose enable bit is zero.
// R6: show-masked resets to one so disabled events can be polled.
// R7: request pin active high when invert zero (reset), low when one.
// R8: invert never changes buffer-empty indication; that is always active high.
// R9: invert setting leaves buffer-empty control behaviour untouched.
// R10: eight-bit enable register at 0x0e, bit n enables event n.
// R11: enable register clears on power-on, deep sleep exit and reset.
// R12: flags at 0x0f read-only, reset zero, fixed event bit order.
// R13: reading flags returns them, then clears all and releases the pin.
// R14: host should read flags once after enabling to drop stale ones.
// R15: stamp enable raises stamp pin on header receipt with frame start.
// R16: stamp pin works even when frame start enable is zero.
// R17: stamp pin stays high until the frame procedure ends.
// R18: all enabled pending events are ORed onto the request pin.
// R19: flags stay set after cause ends; only a flags read, deep sleep exit, reset or the opposite lock/unlock event clears.
// R20: lock flag clears unlock flag and vice versa.
// R21: event in the same cycle as a clearing read survives the read.
module refu_event_flags (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // deep-sleep exit, treated as a register clear
  input  wire logic       sleep_clear,
  // register port, one access per strobe
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // event pulses from the radio core
  input  wire logic [7:0] event_pulse,
  // frame procedure active, ends stamp pulse
  input  wire logic       frame_busy,
  // buffer-empty indication while buffer-empty control is on
  input  wire logic       buffer_empty,
  // pins
  output logic            irq_pin,
  output logic            stamp_output_pin,
  // control bit visible to the rest of the radio
  output logic            buffer_empty_indicator_ctrl
);

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] enable;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic       irq;
    logic       stamp;
    logic       bufctl;
  } refu_state_t;

  refu_state_t st;
  refu_state_t next_st;

  logic rd_flags;
  logic wr_ctrl;
  logic wr_enable;
  logic show_masked;
  logic [7:0] latch_ev;
  logic [7:0] flags_kept;
  logic       req_active;

  assign rd_flags    = reg_rd && (reg_addr == refu_pkg::ADDR_FLAGS);
  assign wr_ctrl     = reg_wr && (reg_addr == refu_pkg::ADDR_CTRL_ONE);
  assign wr_enable   = reg_wr && (reg_addr == refu_pkg::ADDR_ENABLE);
  assign show_masked = st.ctrl_one[refu_pkg::BIT_SHOW_MASK];

  always_comb begin
    next_st = st;
    // masked events flagged only in poll mode
    latch_ev = show_masked ? event_pulse
                           : (event_pulse & st.enable); // [R1] [R3] [R4] [R5] [R2]
    // a read clears history, but same-cycle events survive
    flags_kept = rd_flags ? 8'h00 : st.flags; // [R13] [R19]
    next_st.flags = flags_kept | latch_ev; // [R21] [R19]
    // lock and unlock evict each other
    if (latch_ev[refu_pkg::EV_SYNTH_LOCK] &&
        !latch_ev[refu_pkg::EV_SYNTH_UNLOCK]) begin
      next_st.flags[refu_pkg::EV_SYNTH_UNLOCK] = 1'b0; // [R20]
    end
    if (latch_ev[refu_pkg::EV_SYNTH_UNLOCK] &&
        !latch_ev[refu_pkg::EV_SYNTH_LOCK]) begin
      next_st.flags[refu_pkg::EV_SYNTH_LOCK] = 1'b0; // [R20]
    end
    if (wr_ctrl) begin
      next_st.ctrl_one = reg_wdata;
    end
    if (wr_enable) begin
      next_st.enable = reg_wdata; // [R10]
    end
    if (sleep_clear) begin
      next_st.ctrl_one = refu_pkg::CTRL_ONE_RESET;
      next_st.enable   = refu_pkg::ENABLE_RESET; // [R11]
      next_st.flags    = refu_pkg::FLAGS_RESET;
    end
    // read data captured on the strobe, flags before clearing
    case (reg_addr)
      refu_pkg::ADDR_CTRL_ONE: next_st.rdata = st.ctrl_one;
      refu_pkg::ADDR_ENABLE:   next_st.rdata = st.enable;
      refu_pkg::ADDR_FLAGS:    next_st.rdata = st.flags; // [R12] [R13]
      default:                 next_st.rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      next_st.rdata = st.rdata;
    end
    // poll-only flags never reach the pin
    req_active = |(next_st.flags & next_st.enable); // [R18] [R2] [R3]
    next_st.bufctl = next_st.ctrl_one[refu_pkg::BIT_BUF_EMPTY];
    if (next_st.bufctl) begin
      // buffer-empty is active high whatever the invert bit says
      next_st.irq = buffer_empty; // [R8] [R9]
    end else begin
      next_st.irq = req_active ^
                    next_st.ctrl_one[refu_pkg::BIT_INVERT]; // [R7]
    end
    // stamp pin: set with frame start, held while frame busy
    if (st.ctrl_one[refu_pkg::BIT_STAMP_EN] &&
        event_pulse[refu_pkg::EV_FRAME_START]) begin
      next_st.stamp = 1'b1; // [R15] [R16]
    end else if (!frame_busy) begin
      next_st.stamp = 1'b0; // [R17]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st.ctrl_one <= refu_pkg::CTRL_ONE_RESET; // [R6] [R7]
      st.enable   <= refu_pkg::ENABLE_RESET; // [R11]
      st.flags    <= refu_pkg::FLAGS_RESET; // [R12]
      st.rdata    <= 8'h00;
      st.irq      <= 1'b0;
      st.stamp    <= 1'b0;
      st.bufctl   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata                   = st.rdata;
  assign irq_pin                     = st.irq;
  assign stamp_output_pin            = st.stamp;
  assign buffer_empty_indicator_ctrl = st.bufctl;

endmodule : refu_event_flags

// ---- tb/refu_chk.sv ----
// assertion checker for the radio event flag unit
`timescale 1ns/1ps
module refu_chk (
  input wire logic       mclk, rst_n, sleep_clear, reg_wr, reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, event_pulse,
  input wire logic       frame_busy, buffer_empty, irq_pin,
  input wire logic       stamp_output_pin, buffer_empty_indicator_ctrl
);
  logic [7:0] ctl, en, xr;
  logic       ok;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n || sleep_clear) {ctl, en} <= 16'h2200;
    else if (reg_wr && reg_addr == 6'h04) ctl <= reg_wdata;
    else if (reg_wr && reg_addr == 6'h0e) en <= reg_wdata;
  assign xr = reg_addr == 6'h04 ? ctl : reg_addr == 6'h0e ? en : 8'h00;
  // no register change this edge, so the shadow stays valid
  assign ok = !reg_wr && !sleep_clear;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_quiet; ok && en == 0 && !ctl[4] |=> irq_pin == ctl[0]; endproperty
  a_quiet: assert property (p_quiet) else $error("pin active");
  property p_evt; ok && |(event_pulse & en) && !ctl[4] |=> irq_pin != ctl[0];
  endproperty
  a_evt: assert property (p_evt) else $error("no request");
  property p_clr; ok && reg_rd && reg_addr == 6'h0f && event_pulse == 0 &&
    !ctl[4] |=> irq_pin == ctl[0]; endproperty
  a_clr: assert property (p_clr) else $error("not released");
  property p_buf; ok && ctl[4] |=> irq_pin == $past(buffer_empty); endproperty
  a_buf: assert property (p_buf) else $error("buffer level");
  property p_bctl; buffer_empty_indicator_ctrl == ctl[4]; endproperty
  a_bctl: assert property (p_bctl) else $error("buffer ctrl");
  property p_stamp; ok && ctl[6] && event_pulse[2] |=> stamp_output_pin;
  endproperty
  a_stamp: assert property (p_stamp) else $error("no stamp");
  property p_hold; ok && stamp_output_pin && frame_busy |=> stamp_output_pin;
  endproperty
  a_hold: assert property (p_hold) else $error("stamp dropped");
  property p_rd; ok && reg_rd && reg_addr != 6'h0f |=> reg_rdata == $past(xr);
  endproperty
  a_rd: assert property (p_rd) else $error("read data");
  c_clr: cover property (ok && reg_rd && reg_addr == 6'h0f);
  c_evt: cover property (ok && |(event_pulse & en));
  c_stamp: cover property (stamp_output_pin && !frame_busy);
endmodule : refu_chk
bind refu_event_flags refu_chk i_chk (.*);

// ---- tb/refu_host.sv ----
// host side view of the request pin
`timescale 1ns/1ps
module refu_host (
  input wire logic irq_pin, inv,
  output logic     req
);
  assign req = irq_pin ^ inv; // undo configured polarity
endmodule : refu_host

// ---- tb/testbench.sv ----
// self-checking bench for the radio event flag unit
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, rst_n = 0, sc = 0, wr = 0, rd = 0, fb = 0, be = 0, inv = 0;
  logic rq, irq, stp, bc, rd_d = 0;
  logic [5:0] a = 0;
  logic [7:0] wd = 0, ev = 0, rdat, m, q[$];
  int err_count = 0, n_compared = 0, cyc = 0;
  refu_event_flags i_dut (.mclk(mclk), .rst_n(rst_n), .sleep_clear(sc),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdat),
    .event_pulse(ev), .frame_busy(fb), .buffer_empty(be), .irq_pin(irq),
    .stamp_output_pin(stp), .buffer_empty_indicator_ctrl(bc));
  refu_host i_host (.irq_pin(irq), .inv(inv), .req(rq));
  task cmp(input logic [7:0] g, x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp
  // on a read, d is the expected data
  task op(input logic w, r, input logic [5:0] ad, input logic [7:0] d, e);
    @(posedge mclk);
    {wr, rd, a, wd, ev} <= {w, r, ad, d, e};
    if (r) q.push_back(d);
    @(posedge mclk);
    {wr, rd, ev} <= 10'h000;
  endtask : op
  task pin(input logic x);
    @(negedge mclk);
    cmp({7'h0, rq}, {7'h0, x});
  endtask : pin
  task end_sim;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) rd_d <= rd;
  always @(negedge mclk) if (rd_d) cmp(rdat, q.pop_front());
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(32'hc323));
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    op(0, 1, 6'h04, 8'h22, 0);
    op(0, 1, 6'h0e, 8'h00, 0);
    op(0, 1, 6'h3f, 8'h00, 0);
    m = $urandom;
    op(0, 0, 0, 0, m); pin(0);
    op(0, 1, 6'h0f, m, 0); op(0, 1, 6'h0f, 0, 0);
    op(1, 0, 6'h04, 8'h20, 0); op(0, 0, 0, 0, 8'hff);
    op(0, 1, 6'h0f, 0, 0);
    m = $urandom | 1;
    op(1, 0, 6'h0e, m, 0); op(0, 0, 0, 0, 8'hff); pin(1);
    op(0, 1, 6'h0f, m, 0); pin(0);
    op(1, 0, 6'h0f, 8'hff, 0); pin(0);
    op(1, 0, 6'h0e, 8'hff, 0); op(0, 0, 0, 0, 1); op(0, 0, 0, 0, 2);
    op(0, 1, 6'h0f, 8'h02, 0);
    op(0, 1, 6'h0f, 0, 8'h80); op(0, 1, 6'h0f, 8'h80, 0);
    op(1, 0, 6'h04, 8'h21, 0); inv = 1; pin(0); cmp({7'h0, irq}, 1);
    op(0, 0, 0, 0, 8'h10); pin(1); op(0, 1, 6'h0f, 8'h10, 0);
    be <= 1; op(1, 0, 6'h04, 8'h31, 0); op(0, 0, 0, 0, 0);
    @(negedge mclk);
    cmp({7'h0, irq}, 1); cmp({7'h0, bc}, 1);
    be <= 0; fb <= 1; op(1, 0, 6'h04, 8'h40, 0); op(1, 0, 6'h0e, 0, 0);
    op(0, 0, 0, 0, 8'h04); @(negedge mclk);
    cmp({7'h0, stp}, 1);
    fb <= 0; op(0, 0, 0, 0, 0); @(negedge mclk);
    cmp({7'h0, stp}, 0);
    sc <= 1; op(0, 0, 0, 0, 0); sc <= 0; op(0, 1, 6'h04, 8'h22, 0);
    end_sim;
  end
endmodule : testbench
